// ==== src/iidt_pkg.sv ====
// Shared constants and types for the integer instruction decode timing block
package iidt_pkg;
	localparam int CYC_W = 20;
	localparam int REP_W = 16;
	localparam int FLG_W = 9;

	typedef enum logic [4:0] {
		OP_OTHER, OP_INVALID, OP_POPA, OP_PUSHA, OP_POPF, OP_PUSHF, OP_RDTSC, OP_RDMSR,
		OP_REP_LODS, OP_REP_INS, OP_RCL, OP_RCR, OP_PUSH_RM, OP_PUSH_REG, OP_POP_RM,
		OP_POP_REG, OP_POP_SEG, OP_PUSH_SEG
	} iidt_op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_MODRM = 3'b001,
		ST_IMM = 3'b011,
		ST_EXEC = 3'b010,
		ST_ESC = 3'b100
	} iidt_state_t;

	// Opcode bytes and opcode fields
	localparam logic [7:0] OPC_ESC = 8'h0f;
	localparam logic [7:0] OPC2_INVALID = 8'hff;
	localparam logic [7:0] OPC2_RDTSC = 8'h31;
	localparam logic [7:0] OPC2_RDMSR = 8'h32;
	localparam logic [7:0] OPC_POPA = 8'h61;
	localparam logic [7:0] OPC_PUSHA = 8'h60;
	localparam logic [7:0] OPC_POPF = 8'h9d;
	localparam logic [7:0] OPC_PUSHF = 8'h9c;
	localparam logic [7:0] OPC_LOCK = 8'hf0;
	localparam logic [7:0] OPC_REP = 8'hf3;
	localparam logic [7:0] OPC_GRP_PUSH = 8'hff;
	localparam logic [7:0] OPC_GRP_POP = 8'h8f;
	localparam logic [6:0] OPH_LODS = 7'h56;
	localparam logic [6:0] OPH_INS = 7'h36;
	localparam logic [6:0] OPH_ROT_BY1 = 7'h68;
	localparam logic [6:0] OPH_ROT_CL = 7'h69;
	localparam logic [6:0] OPH_ROT_IMM = 7'h60;
	localparam logic [4:0] OPH_PUSH_REG = 5'h0a;
	localparam logic [4:0] OPH_POP_REG = 5'h0b;
	localparam logic [2:0] OPH_SEG = 3'h0;
	localparam logic [2:0] OPL_SEG_POP = 3'h7;
	localparam logic [2:0] OPL_SEG_PUSH = 3'h6;
	localparam logic [1:0] SREG2_CS = 2'h1;
	localparam logic [2:0] REG_RCL = 3'h2;
	localparam logic [2:0] REG_RCR = 3'h3;
	localparam logic [2:0] REG_PUSH = 3'h6;
	localparam logic [2:0] REG_POP = 3'h0;
	localparam logic [1:0] MOD_REG = 2'h3;

	// Core clocks per instruction, cache hit assumed
	localparam logic [7:0] CYC_ONE = 8'h01;
	localparam logic [7:0] CYC_POPA = 8'h09;
	localparam logic [7:0] CYC_PUSHA = 8'h0b;
	localparam logic [7:0] CYC_POPF = 8'h08;
	localparam logic [7:0] CYC_PUSHF = 8'h02;
	localparam logic [7:0] CYC_INV_REAL = 8'h01;
	localparam logic [7:0] CYC_INV_MIN = 8'h08;
	localparam logic [7:0] CYC_INV_MAX = 8'h7d;
	localparam logic [7:0] CYC_LODS_BASE = 8'h09;
	localparam logic [2:0] CYC_LODS_PER = 3'h2;
	localparam logic [7:0] CYC_INS_BASE = 8'h11;
	localparam logic [7:0] CYC_INS_BASE_CHK = 8'h20;
	localparam logic [2:0] CYC_INS_PER = 3'h4;
	localparam logic [7:0] CYC_RCL_BY1 = 8'h03;
	localparam logic [7:0] CYC_RCR_BY1 = 8'h04;
	localparam logic [7:0] CYC_ROT_MULTI = 8'h08;
	localparam logic [7:0] CYC_PUSH_MEM = 8'h03;
	localparam logic [7:0] CYC_POP_MEM = 8'h04;
	localparam logic [7:0] CYC_POP_SEG_PROT = 8'h06;
	localparam logic [7:0] CYC_RDTSC = 8'h01;
	localparam logic [7:0] CYC_RDMSR = 8'h01;

	// Flag positions: OF DF IF TF SF ZF AF PF CF
	localparam int FLG_CF = 0;
	localparam int FLG_TF = 5;
	localparam int FLG_IF = 6;
	localparam int FLG_OF = 8;
	localparam logic [8:0] FLG_ALL = 9'h1ff;
	localparam logic [8:0] FLG_NONE = 9'h000;
endpackage

// ==== src/iidt_cls_if.sv ====
// Carrier between the decoder sequencer and its opcode classifier
`timescale 1ns/1ps
interface iidt_cls_if;
	logic [7:0] opcode;
	logic [7:0] modrm;
	logic escaped;
	logic rep;
	logic prot;
	logic io_slow;
	iidt_pkg::iidt_op_t op;
	logic [7:0] base_cyc;
	logic [2:0] per_cyc;
	logic use_n;
	logic needs_modrm;
	logic needs_imm;
	logic wide;
	logic [8:0] flg_clr;
	logic [8:0] flg_alt;

	modport classifier (
		input opcode, modrm, escaped, rep, prot, io_slow,
		output op, base_cyc, per_cyc, use_n, needs_modrm, needs_imm, wide, flg_clr, flg_alt
	);
	modport user (
		output opcode, modrm, escaped, rep, prot, io_slow,
		input op, base_cyc, per_cyc, use_n, needs_modrm, needs_imm, wide, flg_clr, flg_alt
	);
endinterface

// ==== src/iidt_classify.sv ====
// Opcode classifier: operation, clock cost and flag effect per opcode
`timescale 1ns/1ps
module iidt_classify (
	iidt_cls_if.classifier cls
);
	logic [2:0] reg_fld;
	logic by1;

	always_comb begin
		reg_fld = cls.modrm[5:3];
		by1 = (cls.opcode[7:1] == iidt_pkg::OPH_ROT_BY1);
		cls.op = iidt_pkg::OP_OTHER;
		cls.base_cyc = iidt_pkg::CYC_ONE;
		cls.per_cyc = 3'h0;
		cls.use_n = 1'b0;
		cls.needs_modrm = 1'b0;
		cls.needs_imm = (cls.opcode[7:1] == iidt_pkg::OPH_ROT_IMM) && !cls.escaped;
		cls.wide = cls.opcode[0];
		cls.flg_clr = iidt_pkg::FLG_NONE;
		cls.flg_alt = iidt_pkg::FLG_NONE;
		if (cls.escaped) begin
			case (cls.opcode)
				iidt_pkg::OPC2_INVALID: begin
					cls.op = iidt_pkg::OP_INVALID;
					cls.base_cyc = iidt_pkg::CYC_INV_REAL;
					cls.flg_clr[iidt_pkg::FLG_TF] = 1'b1;
					cls.flg_alt[iidt_pkg::FLG_IF] = 1'b1;
				end
				iidt_pkg::OPC2_RDTSC: begin
					cls.op = iidt_pkg::OP_RDTSC;
					cls.base_cyc = iidt_pkg::CYC_RDTSC;
				end
				iidt_pkg::OPC2_RDMSR: begin
					cls.op = iidt_pkg::OP_RDMSR;
					cls.base_cyc = iidt_pkg::CYC_RDMSR;
				end
				default: cls.op = iidt_pkg::OP_OTHER;
			endcase
		end else if (cls.opcode == iidt_pkg::OPC_POPA) begin
			cls.op = iidt_pkg::OP_POPA;
			cls.base_cyc = iidt_pkg::CYC_POPA;
		end else if (cls.opcode == iidt_pkg::OPC_PUSHA) begin
			cls.op = iidt_pkg::OP_PUSHA;
			cls.base_cyc = iidt_pkg::CYC_PUSHA;
		end else if (cls.opcode == iidt_pkg::OPC_POPF) begin
			cls.op = iidt_pkg::OP_POPF;
			cls.base_cyc = iidt_pkg::CYC_POPF;
			cls.flg_alt = iidt_pkg::FLG_ALL;
		end else if (cls.opcode == iidt_pkg::OPC_PUSHF) begin
			cls.op = iidt_pkg::OP_PUSHF;
			cls.base_cyc = iidt_pkg::CYC_PUSHF;
		end else if (cls.rep && cls.opcode[7:1] == iidt_pkg::OPH_LODS) begin
			cls.op = iidt_pkg::OP_REP_LODS;
			cls.base_cyc = iidt_pkg::CYC_LODS_BASE;
			cls.per_cyc = iidt_pkg::CYC_LODS_PER;
			cls.use_n = 1'b1;
		end else if (cls.rep && cls.opcode[7:1] == iidt_pkg::OPH_INS) begin
			cls.op = iidt_pkg::OP_REP_INS;
			cls.base_cyc = (cls.prot && cls.io_slow) ? iidt_pkg::CYC_INS_BASE_CHK :
				iidt_pkg::CYC_INS_BASE;
			cls.per_cyc = iidt_pkg::CYC_INS_PER;
			cls.use_n = 1'b1;
		end else if (cls.opcode[7:1] == iidt_pkg::OPH_ROT_BY1 ||
			cls.opcode[7:1] == iidt_pkg::OPH_ROT_CL ||
			cls.opcode[7:1] == iidt_pkg::OPH_ROT_IMM) begin
			cls.needs_modrm = 1'b1;
			if (reg_fld == iidt_pkg::REG_RCL || reg_fld == iidt_pkg::REG_RCR) begin
				cls.op = (reg_fld == iidt_pkg::REG_RCL) ? iidt_pkg::OP_RCL : iidt_pkg::OP_RCR;
				cls.base_cyc = !by1 ? iidt_pkg::CYC_ROT_MULTI :
					(reg_fld == iidt_pkg::REG_RCL) ? iidt_pkg::CYC_RCL_BY1 :
					iidt_pkg::CYC_RCR_BY1;
				cls.flg_alt[iidt_pkg::FLG_OF] = 1'b1;
				cls.flg_alt[iidt_pkg::FLG_CF] = 1'b1;
			end
		end else if (cls.opcode == iidt_pkg::OPC_GRP_PUSH) begin
			cls.needs_modrm = 1'b1;
			if (reg_fld == iidt_pkg::REG_PUSH) begin
				cls.op = iidt_pkg::OP_PUSH_RM;
				cls.base_cyc = (cls.modrm[7:6] == iidt_pkg::MOD_REG) ? iidt_pkg::CYC_ONE :
					iidt_pkg::CYC_PUSH_MEM;
			end
		end else if (cls.opcode == iidt_pkg::OPC_GRP_POP) begin
			cls.needs_modrm = 1'b1;
			if (reg_fld == iidt_pkg::REG_POP) begin
				cls.op = iidt_pkg::OP_POP_RM;
				cls.base_cyc = (cls.modrm[7:6] == iidt_pkg::MOD_REG) ? iidt_pkg::CYC_ONE :
					iidt_pkg::CYC_POP_MEM;
			end
		end else if (cls.opcode[7:3] == iidt_pkg::OPH_PUSH_REG) begin
			cls.op = iidt_pkg::OP_PUSH_REG;
		end else if (cls.opcode[7:3] == iidt_pkg::OPH_POP_REG) begin
			cls.op = iidt_pkg::OP_POP_REG;
		end else if (cls.opcode[7:5] == iidt_pkg::OPH_SEG &&
			cls.opcode[2:0] == iidt_pkg::OPL_SEG_POP && cls.opcode[4:3] != iidt_pkg::SREG2_CS) begin
			cls.op = iidt_pkg::OP_POP_SEG;
			cls.base_cyc = cls.prot ? iidt_pkg::CYC_POP_SEG_PROT : iidt_pkg::CYC_ONE;
		end else if (cls.opcode[7:5] == iidt_pkg::OPH_SEG &&
			cls.opcode[2:0] == iidt_pkg::OPL_SEG_PUSH) begin
			cls.op = iidt_pkg::OP_PUSH_SEG;
		end
	end
endmodule

// ==== src/iidt_cycle_timer.sv ====
// Execution clock counter: holds busy for a loaded number of core clocks
`timescale 1ns/1ps
module iidt_cycle_timer (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic start,
	input wire logic [19:0] load,
	output logic busy,
	output logic done
);
	logic [19:0] cnt_reg;
	logic [19:0] len_reg;
	logic [19:0] elapsed_reg;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cnt_reg <= 20'h00000;
			len_reg <= 20'h00000;
		end else if (start) begin
			cnt_reg <= load;
			len_reg <= load;
		end else if (cnt_reg != 20'h00000) begin
			cnt_reg <= cnt_reg - 20'h00001;
		end
	end

	assign busy = (cnt_reg != 20'h00000);
	assign done = (cnt_reg == 20'h00001);

	// Helper: clocks since start
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			elapsed_reg <= 20'h00000;
		end else if (start) begin
			elapsed_reg <= 20'h00001;
		end else if (busy) begin
			elapsed_reg <= elapsed_reg + 20'h00001;
		end
	end

	property p_timer_len;
		@(posedge clk_sys) disable iff (reset) done |-> elapsed_reg == len_reg;
	endproperty
	a_timer_len: assert property (p_timer_len) else $error("done at wrong clock count");
endmodule

// ==== src/iidt_decoder.sv ====
// Integer decoder and sequencer for one slice of the instruction table
`timescale 1ns/1ps
module iidt_decoder (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] instr_byte,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic prot_mode,
	input wire logic cache_hit,
	input wire logic [7:0] miss_cycles,
	input wire logic [15:0] rep_count,
	input wire logic io_priv_slow,
	input wire logic [7:0] fault_cycles,
	output logic busy,
	output logic exec_done,
	output iidt_pkg::iidt_op_t exec_op,
	output logic exec_wide,
	output logic exec_lock,
	output logic [19:0] exec_cycles,
	output logic [8:0] flags_clear,
	output logic [8:0] flags_alter
);
	iidt_pkg::iidt_state_t state_reg;
	iidt_pkg::iidt_state_t state_next;
	logic lock_reg;
	logic rep_reg;
	logic [7:0] opc_reg;
	logic [7:0] modrm_reg;
	iidt_pkg::iidt_op_t op_reg;
	logic wide_reg;
	logic [19:0] cycles_reg;
	logic [8:0] clr_reg;
	logic [8:0] alt_reg;
	logic take;
	logic launch;
	logic [7:0] inv_prot_cyc;
	logic [7:0] base_eff;
	logic [19:0] n_term;
	logic [19:0] total;
	logic timer_busy;
	logic timer_done;

	iidt_cls_if cls();

	iidt_classify u_classify (
		.cls(cls)
	);

	iidt_cycle_timer u_timer (
		.clk_sys(clk_sys),
		.reset(reset),
		.start(launch),
		.load(total),
		.busy(timer_busy),
		.done(timer_done)
	);

	// ************************************************************
	// Byte intake and classification inputs
	// ************************************************************
	// No byte is taken while an instruction is counting its clocks
	assign instr_ready = (state_reg != iidt_pkg::ST_EXEC);
	assign take = instr_valid && instr_ready;

	assign cls.opcode = (state_reg == iidt_pkg::ST_IDLE || state_reg == iidt_pkg::ST_ESC) ?
		instr_byte : opc_reg;
	assign cls.modrm = (state_reg == iidt_pkg::ST_MODRM) ? instr_byte : modrm_reg;
	assign cls.escaped = (state_reg == iidt_pkg::ST_ESC);
	assign cls.rep = rep_reg;
	assign cls.prot = prot_mode;
	assign cls.io_slow = io_priv_slow;

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		launch = 1'b0;
		case (state_reg)
			iidt_pkg::ST_IDLE: begin
				if (take) begin
					if (instr_byte == iidt_pkg::OPC_ESC) begin
						state_next = iidt_pkg::ST_ESC;
					end else if (instr_byte == iidt_pkg::OPC_LOCK ||
						instr_byte == iidt_pkg::OPC_REP) begin
						state_next = iidt_pkg::ST_IDLE;
					end else if (cls.needs_modrm) begin
						state_next = iidt_pkg::ST_MODRM;
					end else begin
						launch = 1'b1;
					end
				end
			end
			iidt_pkg::ST_ESC: begin
				launch = take;
			end
			iidt_pkg::ST_MODRM: begin
				if (take) begin
					if (cls.needs_imm) begin
						state_next = iidt_pkg::ST_IMM;
					end else begin
						launch = 1'b1;
					end
				end
			end
			iidt_pkg::ST_IMM: begin
				launch = take;
			end
			iidt_pkg::ST_EXEC: begin
				if (timer_done) begin
					state_next = iidt_pkg::ST_IDLE;
				end
			end
			default: state_next = iidt_pkg::ST_IDLE;
		endcase
		if (launch) begin
			state_next = iidt_pkg::ST_EXEC;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg <= iidt_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// Prefix capture
	// ************************************************************
	// Prefixes live until the instruction they precede retires
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			lock_reg <= 1'b0;
			rep_reg <= 1'b0;
		end else if (timer_done) begin
			lock_reg <= 1'b0;
			rep_reg <= 1'b0;
		end else if (take && state_reg == iidt_pkg::ST_IDLE) begin
			if (instr_byte == iidt_pkg::OPC_LOCK) begin
				lock_reg <= 1'b1;
			end
			if (instr_byte == iidt_pkg::OPC_REP) begin
				rep_reg <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Opcode and operand byte capture
	// ************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			opc_reg <= 8'h00;
			modrm_reg <= 8'h00;
		end else if (take) begin
			if (state_reg == iidt_pkg::ST_IDLE) begin
				opc_reg <= instr_byte;
			end
			if (state_reg == iidt_pkg::ST_MODRM) begin
				modrm_reg <= instr_byte;
			end
		end
	end

	// ************************************************************
	// Clock cost
	// ************************************************************
	// protected fault time bounded
	assign inv_prot_cyc = (fault_cycles < iidt_pkg::CYC_INV_MIN) ? iidt_pkg::CYC_INV_MIN :
		(fault_cycles > iidt_pkg::CYC_INV_MAX) ? iidt_pkg::CYC_INV_MAX : fault_cycles;
	assign base_eff = (cls.op == iidt_pkg::OP_INVALID && prot_mode) ? inv_prot_cyc :
		cls.base_cyc;
	assign n_term = cls.use_n ? 20'(20'(cls.per_cyc) * 20'(rep_count)) : 20'h00000;
	assign total = 20'(base_eff) + n_term + (cache_hit ? 20'h00000 : 20'(miss_cycles));

	// ************************************************************
	// Result registers
	// ************************************************************
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			op_reg <= iidt_pkg::OP_OTHER;
			wide_reg <= 1'b0;
			cycles_reg <= 20'h00000;
			clr_reg <= iidt_pkg::FLG_NONE;
			alt_reg <= iidt_pkg::FLG_NONE;
		end else if (launch) begin
			op_reg <= cls.op;
			wide_reg <= cls.wide;
			cycles_reg <= total;
			clr_reg <= cls.flg_clr;
			alt_reg <= cls.flg_alt;
		end
	end

	assign busy = timer_busy;
	assign exec_done = timer_done;
	assign exec_op = op_reg;
	assign exec_wide = wide_reg;
	assign exec_lock = lock_reg && (state_reg == iidt_pkg::ST_EXEC);
	assign exec_cycles = cycles_reg;
	assign flags_clear = clr_reg;
	assign flags_alter = alt_reg;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_invalid_prot;
		@(posedge clk_sys) disable iff (reset)
		launch && cls.op == iidt_pkg::OP_INVALID && prot_mode && cache_hit |=>
		exec_cycles >= 20'd8 && exec_cycles <= 20'd125 && flags_clear[5] && flags_alter[6];
	endproperty
	a_invalid_prot: assert property (p_invalid_prot) else $error("invalid opcode cost");

	property p_popa;
		@(posedge clk_sys) disable iff (reset)
		launch && cls.op == iidt_pkg::OP_POPA && cache_hit |=> ##8 exec_done;
	endproperty
	a_popa: assert property (p_popa) else $error("pop all not 9 clocks");

	property p_pusha;
		@(posedge clk_sys) disable iff (reset)
		launch && cls.op == iidt_pkg::OP_PUSHA && cache_hit |=> busy ##10 exec_done ##1 !busy;
	endproperty
	a_pusha: assert property (p_pusha) else $error("push all not 11 clocks");

	property p_popf;
		@(posedge clk_sys) disable iff (reset)
		launch && cls.op == iidt_pkg::OP_POPF && cache_hit |=>
		exec_cycles == 20'd8 && flags_alter == 9'h1ff;
	endproperty
	a_popf: assert property (p_popf) else $error("flag load wrong");

	property p_pushf;
		@(posedge clk_sys) disable iff (reset)
		launch && cls.op == iidt_pkg::OP_PUSHF && cache_hit |=> !exec_done ##1 exec_done;
	endproperty
	a_pushf: assert property (p_pushf) else $error("flag store not 2 clocks");

	property p_no_flags;
		@(posedge clk_sys) disable iff (reset)
		launch && (cls.op == iidt_pkg::OP_RDTSC || cls.op == iidt_pkg::OP_RDMSR) |=>
		flags_alter == 9'h000 && flags_clear == 9'h000;
	endproperty
	a_no_flags: assert property (p_no_flags) else $error("read op touched flags");

	property p_lock;
		@(posedge clk_sys) disable iff (reset)
		take && state_reg == iidt_pkg::ST_IDLE && instr_byte == 8'hf0 |=>
		lock_reg throughout (state_reg != iidt_pkg::ST_EXEC) [*1] ##0 lock_reg;
	endproperty
	a_lock: assert property (p_lock) else $error("lock prefix lost");

	property p_lods;
		@(posedge clk_sys) disable iff (reset)
		launch && cls.op == iidt_pkg::OP_REP_LODS && cache_hit |=>
		exec_cycles == 20'd9 + 20'd2 * 20'($past(rep_count));
	endproperty
	a_lods: assert property (p_lods) else $error("repeated load cost");

	property p_rcl;
		@(posedge clk_sys) disable iff (reset)
		launch && cls.op == iidt_pkg::OP_RCL && cache_hit |=>
		exec_cycles == ($past(opc_reg[7:1]) == 7'h68 ? 20'd3 : 20'd8);
	endproperty
	a_rcl: assert property (p_rcl) else $error("rotate left cost");

	property p_rcr;
		@(posedge clk_sys) disable iff (reset)
		launch && cls.op == iidt_pkg::OP_RCR && cache_hit |=>
		exec_cycles == ($past(opc_reg[7:1]) == 7'h68 ? 20'd4 : 20'd8);
	endproperty
	a_rcr: assert property (p_rcr) else $error("rotate right cost");

	property p_seg_pop;
		@(posedge clk_sys) disable iff (reset)
		launch && cls.op == iidt_pkg::OP_POP_SEG && cache_hit |=>
		exec_cycles == ($past(prot_mode) ? 20'd6 : 20'd1);
	endproperty
	a_seg_pop: assert property (p_seg_pop) else $error("segment pop cost");
endmodule

// ==== testbench/iidt_testbench.sv ====
// Self-checking bench for the integer instruction decode timing block
`timescale 1ns/1ps
module testbench;
	logic clk_sys, reset, instr_valid, instr_ready, prot_mode, cache_hit, io_priv_slow;
	logic busy, exec_done, exec_wide, exec_lock;
	logic [7:0] instr_byte, miss_cycles, fault_cycles;
	logic [15:0] rep_count;
	logic [19:0] exec_cycles;
	logic [8:0] flags_clear, flags_alter;
	iidt_pkg::iidt_op_t exec_op;
	int err_total, n_checks;

	iidt_decoder u_iidt_decoder (
		.clk_sys(clk_sys), .reset(reset), .instr_byte(instr_byte),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .prot_mode(prot_mode),
		.cache_hit(cache_hit), .miss_cycles(miss_cycles), .rep_count(rep_count),
		.io_priv_slow(io_priv_slow), .fault_cycles(fault_cycles), .busy(busy),
		.exec_done(exec_done), .exec_op(exec_op), .exec_wide(exec_wide),
		.exec_lock(exec_lock), .exec_cycles(exec_cycles), .flags_clear(flags_clear),
		.flags_alter(flags_alter)
	);

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Valid stays high between bytes of one instruction
	task automatic send(input logic [7:0] b);
		int k;
		k = 0;
		while (instr_ready !== 1'b1 && k < 500) begin
			step();
			k++;
		end
		instr_byte = b;
		instr_valid = 1'b1;
		step();
	endtask

	// Bytes lie lowest-last in bs; cost counted from the launch edge
	task automatic run(input logic [31:0] bs, input int nb, input iidt_pkg::iidt_op_t op,
		input logic [19:0] cyc, input logic [8:0] fc, input logic [8:0] fa, input logic lk);
		int k;
		for (int i = 0; i < nb; i++)
			send(bs[8*(nb-1-i) +: 8]);
		instr_valid = 1'b0;
		check(exec_op === op, "operation");
		check(exec_cycles === cyc, "clock count");
		check(flags_clear === fc && flags_alter === fa, "flag effect");
		check(exec_lock === lk, "lock");
		check(busy === 1'b1 && instr_ready === 1'b0, "byte taken while busy");
		k = 1;
		while (exec_done !== 1'b1 && k < 2000) begin
			step();
			k++;
		end
		check(k == cyc, "done timing");
		step();
		check(instr_ready === 1'b1 && busy === 1'b0, "not ready after done");
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		check(instr_ready === 1'b1 && busy === 1'b0 && exec_done === 1'b0, "reset outputs");
		check(exec_op === iidt_pkg::OP_OTHER && exec_cycles === 20'h0, "reset regs");
		check(exec_lock === 1'b0 && exec_wide === 1'b0, "reset lock and width");
		check(flags_clear === 9'h000 && flags_alter === 9'h000, "reset flag effect");
	endtask

	task automatic t_stack();
		run(32'h61, 1, iidt_pkg::OP_POPA, 20'h09, 9'h000, 9'h000, 1'b0);
		run(32'h60, 1, iidt_pkg::OP_PUSHA, 20'h0b, 9'h000, 9'h000, 1'b0);
		run(32'h9d, 1, iidt_pkg::OP_POPF, 20'h08, 9'h000, 9'h1ff, 1'b0);
		run(32'h9c, 1, iidt_pkg::OP_PUSHF, 20'h02, 9'h000, 9'h000, 1'b0);
		prot_mode = 1'b1;
		run(32'h61, 1, iidt_pkg::OP_POPA, 20'h09, 9'h000, 9'h000, 1'b0);
		run(32'h60, 1, iidt_pkg::OP_PUSHA, 20'h0b, 9'h000, 9'h000, 1'b0);
		prot_mode = 1'b0;
	endtask

	task automatic t_escape();
		run(32'h0fff, 2, iidt_pkg::OP_INVALID, 20'h01, 9'h020, 9'h040, 1'b0);
		prot_mode = 1'b1;
		fault_cycles = 8'h03;
		run(32'h0fff, 2, iidt_pkg::OP_INVALID, 20'h08, 9'h020, 9'h040, 1'b0);
		fault_cycles = 8'hc8;
		run(32'h0fff, 2, iidt_pkg::OP_INVALID, 20'h7d, 9'h020, 9'h040, 1'b0);
		fault_cycles = 8'h32;
		run(32'h0fff, 2, iidt_pkg::OP_INVALID, 20'h32, 9'h020, 9'h040, 1'b0);
		prot_mode = 1'b0;
		run(32'h0f31, 2, iidt_pkg::OP_RDTSC, 20'h01, 9'h000, 9'h000, 1'b0);
		run(32'h0f32, 2, iidt_pkg::OP_RDMSR, 20'h01, 9'h000, 9'h000, 1'b0);
	endtask

	task automatic t_string();
		run(32'hf061, 2, iidt_pkg::OP_POPA, 20'h09, 9'h000, 9'h000, 1'b1);
		run(32'h61, 1, iidt_pkg::OP_POPA, 20'h09, 9'h000, 9'h000, 1'b0);
		rep_count = 16'h0003;
		run(32'hf3ac, 2, iidt_pkg::OP_REP_LODS, 20'h0f, 9'h000, 9'h000, 1'b0);
		check(exec_wide === 1'b0, "byte width");
		rep_count = 16'h0000;
		run(32'hf3ad, 2, iidt_pkg::OP_REP_LODS, 20'h09, 9'h000, 9'h000, 1'b0);
		check(exec_wide === 1'b1, "full width");
		rep_count = 16'h0002;
		run(32'hf36c, 2, iidt_pkg::OP_REP_INS, 20'h19, 9'h000, 9'h000, 1'b0);
		prot_mode = 1'b1;
		io_priv_slow = 1'b1;
		run(32'hf36d, 2, iidt_pkg::OP_REP_INS, 20'h28, 9'h000, 9'h000, 1'b0);
		io_priv_slow = 1'b0;
		run(32'hf0f36c, 3, iidt_pkg::OP_REP_INS, 20'h19, 9'h000, 9'h000, 1'b1);
		prot_mode = 1'b0;
	endtask

	task automatic t_rotate();
		run(32'hd1d0, 2, iidt_pkg::OP_RCL, 20'h03, 9'h000, 9'h101, 1'b0);
		run(32'hd3d0, 2, iidt_pkg::OP_RCL, 20'h08, 9'h000, 9'h101, 1'b0);
		run(32'hc1d005, 3, iidt_pkg::OP_RCL, 20'h08, 9'h000, 9'h101, 1'b0);
		run(32'hd0d8, 2, iidt_pkg::OP_RCR, 20'h04, 9'h000, 9'h101, 1'b0);
		run(32'hd2d8, 2, iidt_pkg::OP_RCR, 20'h08, 9'h000, 9'h101, 1'b0);
		run(32'hc0d805, 3, iidt_pkg::OP_RCR, 20'h08, 9'h000, 9'h101, 1'b0);
		check(exec_wide === 1'b0, "byte width");
	endtask

	task automatic t_pushpop();
		run(32'hfff0, 2, iidt_pkg::OP_PUSH_RM, 20'h01, 9'h000, 9'h000, 1'b0);
		run(32'hff30, 2, iidt_pkg::OP_PUSH_RM, 20'h03, 9'h000, 9'h000, 1'b0);
		run(32'h53, 1, iidt_pkg::OP_PUSH_REG, 20'h01, 9'h000, 9'h000, 1'b0);
		run(32'h8fc0, 2, iidt_pkg::OP_POP_RM, 20'h01, 9'h000, 9'h000, 1'b0);
		run(32'h8f00, 2, iidt_pkg::OP_POP_RM, 20'h04, 9'h000, 9'h000, 1'b0);
		run(32'h5b, 1, iidt_pkg::OP_POP_REG, 20'h01, 9'h000, 9'h000, 1'b0);
		run(32'h07, 1, iidt_pkg::OP_POP_SEG, 20'h01, 9'h000, 9'h000, 1'b0);
		run(32'h0e, 1, iidt_pkg::OP_PUSH_SEG, 20'h01, 9'h000, 9'h000, 1'b0);
		prot_mode = 1'b1;
		run(32'h1f, 1, iidt_pkg::OP_POP_SEG, 20'h06, 9'h000, 9'h000, 1'b0);
		run(32'h16, 1, iidt_pkg::OP_PUSH_SEG, 20'h01, 9'h000, 9'h000, 1'b0);
		prot_mode = 1'b0;
	endtask

	// Miss penalty stacks on top of the hit cost
	task automatic t_miss();
		cache_hit = 1'b0;
		run(32'h9c, 1, iidt_pkg::OP_PUSHF, 20'h07, 9'h000, 9'h000, 1'b0);
		rep_count = 16'h0001;
		run(32'hf3ac, 2, iidt_pkg::OP_REP_LODS, 20'h10, 9'h000, 9'h000, 1'b0);
		cache_hit = 1'b1;
	endtask

	// Forms outside the slice decode as other, one clock
	task automatic t_other();
		run(32'h0f00, 2, iidt_pkg::OP_OTHER, 20'h01, 9'h000, 9'h000, 1'b0);
		run(32'hd1c0, 2, iidt_pkg::OP_OTHER, 20'h01, 9'h000, 9'h000, 1'b0);
		run(32'hffc0, 2, iidt_pkg::OP_OTHER, 20'h01, 9'h000, 9'h000, 1'b0);
		run(32'h8fc8, 2, iidt_pkg::OP_OTHER, 20'h01, 9'h000, 9'h000, 1'b0);
	endtask

	// Reset mid-stream drops a pending lock prefix
	task automatic t_midreset();
		send(8'hf0);
		instr_valid = 1'b0;
		reset = 1'b1;
		step();
		reset = 1'b0;
		t_reset();
		run(32'h61, 1, iidt_pkg::OP_POPA, 20'h09, 9'h000, 9'h000, 1'b0);
	endtask

	// ************************************************************
	// Clock, reset, sequence and watchdog
	// ************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	initial begin
		#20000;
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_sim();
	end

	initial begin
		err_total = 0;
		n_checks = 0;
		reset = 1'b1;
		instr_valid = 1'b0;
		instr_byte = 8'h00;
		prot_mode = 1'b0;
		cache_hit = 1'b1;
		miss_cycles = 8'h05;
		rep_count = 16'h0000;
		io_priv_slow = 1'b0;
		fault_cycles = 8'h08;
		repeat (16) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		t_reset();
		t_stack();
		t_escape();
		t_string();
		t_rotate();
		t_pushpop();
		t_miss();
		t_other();
		t_midreset();
		end_sim();
	end
endmodule
